// *** rtl/ntbw_pkg.sv ***
// Purpose: Constants for the paired address-window sizing and translation block.
// Assumes: Eight-bit byte register address on a plain strobe port, 32-bit data.
// Notes: Window 0 is the lower window of the pair, window 1 the upper one.
package ntbw_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_LO_SETUP = 8'h8c;
  localparam logic [7:0] OFS_LO_TBASE = 8'h90;
  localparam logic [7:0] OFS_UP_SETUP = 8'h94;
  localparam logic [7:0] OFS_UP_TBASE = 8'h98;
  localparam logic [7:0] OFS_LO_BASE = 8'hb0;
  localparam logic [7:0] OFS_UP_BASE = 8'hb4;
  localparam int SPACE_BIT = 0;
  localparam int TYPE_LSB = 1;
  localparam int TYPE_MSB = 2;
  localparam int PREF_BIT = 3;
  localparam int SIZE_LSB = 4;
  localparam int SIZE_MSB = 9;
  localparam int EN_BIT = 31;
  localparam int BASE_LSB = 4;
  localparam logic [1:0] TYPE_ADDR32 = 2'h0;
  localparam logic [1:0] TYPE_ADDR64 = 2'h2;
  localparam logic SPACE_MEM = 1'b0;
  localparam logic [5:0] SIZE_MIN = 6'h04;
  localparam logic [5:0] SIZE_RST = 6'h01;
  localparam logic [1:0] TYPE_RST = 2'h0;
  localparam logic SPACE_RST = 1'b0;
  localparam logic PREF_RST = 1'b0;
  localparam logic EN_RST = 1'b0;
  localparam logic [31:0] TBASE_RST = 32'h0000_0000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
endpackage

// *** rtl/ntbw_window.sv ***
// Purpose: Setup, base, translated-base registers and address translation for a window pair.
// Assumes: Strobes and translation requests come from logic on clk; por is power-on only.
// Notes: Enable and translated base are cleared only by por, never by rst.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// Function
// [RL1] Window size requested is two to the size field; zero means full 64-bit space; at zero the code makes every base bit writable.
// [RL2] Base field bit zero maps to bus address bit four, upward in order.
// [RL3] Size zero makes every base bit of the window writable.
// [RL4] Size four or more: base bits at or above size writable; lower ones read zero.
// [RL5] Size one to three forces all base bits to read-only zero, disabling the window.
// [RL6] Size four, a 16-byte window, is accepted as smallest I/O window.
// [RL7] Software keeps memory windows at least 128 bytes, I/O at most 256.
// [RL8] While enable bit 31 is clear the window is off and reads zero.
// [RL9] Enable and translated base survive fundamental and hot reset; the code clears both on por and keeps them only across rst.
// [RL10] In 64-bit pair mode upper translated base is the top half of lower's.
// [RL11] In 64-bit pair mode all 32 upper translated-base bits are read-write.
// [RL12] Translation replaces address bits 31 down to size with translated-base bits.
// [RL13] In 64-bit pair mode the upper setup register reads zero, ignores writes.
// [RL14] Address bits below the size position pass through translation unchanged.
module ntbw_window (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [ntbw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic xl_req,
  input wire logic xl_win,
  input wire logic [63:0] xl_addr,
  output logic xl_ack,
  output logic xl_hit,
  output logic [63:0] xl_out
);

  // Bit k of the result is set where bus address bit k is writable and translated.
  function automatic logic [63:0] win_mask(input logic [5:0] size);
    logic [63:0] m;
    m = 64'h0;
    for (int i = ntbw_pkg::BASE_LSB; i < 64; i++) begin
      m[i] = (size == 6'h00) || (size >= ntbw_pkg::SIZE_MIN && i >= int'(size)); // RL3 RL4 RL5
    end
    return m;
  endfunction

  // Low nibble of a base register reports the window's attributes from its setup.
  function automatic logic [31:0] attr_bits(input logic pref, input logic [1:0] typ, input logic space);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ntbw_pkg::PREF_BIT] = pref;
    w[ntbw_pkg::TYPE_MSB:ntbw_pkg::TYPE_LSB] = typ;
    w[ntbw_pkg::SPACE_BIT] = space;
    return w;
  endfunction

  // Setup word as software reads it back; reserved bits are zero.
  function automatic logic [31:0] setup_word(input logic en, input logic [5:0] size, input logic pref,
    input logic [1:0] typ, input logic space);
    logic [31:0] w;
    w = attr_bits(pref, typ, space);
    w[ntbw_pkg::SIZE_MSB:ntbw_pkg::SIZE_LSB] = size;
    w[ntbw_pkg::EN_BIT] = en;
    return w;
  endfunction

  // Outside pair mode the low nibble of a translated base is reserved and reads zero.
  function automatic logic [31:0] tbase_word(input logic [31:0] tb, input logic full);
    logic [31:0] w;
    w = tb;
    if (!full) begin
      w[ntbw_pkg::BASE_LSB-1:0] = 4'h0;
    end
    return w;
  endfunction

  // The pair forms only when the lower window is memory space with 64-bit decoding.
  function automatic logic pair_mode(input logic space, input logic [1:0] typ);
    return (space == ntbw_pkg::SPACE_MEM) && (typ == ntbw_pkg::TYPE_ADDR64);
  endfunction

  logic space_r [2];
  logic [1:0] type_r [2];
  logic pref_r [2];
  logic [5:0] size_r [2];
  logic en_r [2];
  logic [31:0] tbase_r [2];
  logic [31:0] base_r [2];
  logic pair;
  logic [63:0] mask_lo;
  logic [63:0] mask_up;
  logic [31:0] setup_rd [2];
  logic [31:0] base_rd [2];
  logic [31:0] tbase_rd [2];
  logic [31:0] rdata_nxt;
  logic [63:0] xl_base;
  logic [63:0] xl_tbase;
  logic [63:0] xl_mask;
  logic xl_valid;
  logic [63:0] out_nxt;
  logic hit_nxt;
  logic [63:0] lo_mask;
  logic [63:0] lo_base;
  logic [63:0] lo_tbase;
  logic lo_valid;
  logic [63:0] up_mask;
  logic [63:0] up_base;
  logic [63:0] up_tbase;
  logic up_valid;
  logic addr_match;
  logic span_ok;

  assign pair = pair_mode(space_r[0], type_r[0]);
  assign mask_lo = win_mask(size_r[0]); // RL1
  assign mask_up = win_mask(size_r[1]);

  for (genvar g = 0; g < 2; g++) begin : gen_win
    localparam logic [7:0] SETUP_OFS = (g == 0) ? ntbw_pkg::OFS_LO_SETUP : ntbw_pkg::OFS_UP_SETUP;
    localparam logic [7:0] TBASE_OFS = (g == 0) ? ntbw_pkg::OFS_LO_TBASE : ntbw_pkg::OFS_UP_TBASE;
    localparam logic [7:0] BASE_OFS = (g == 0) ? ntbw_pkg::OFS_LO_BASE : ntbw_pkg::OFS_UP_BASE;
    logic setup_wr;
    logic frozen;
    logic [63:0] wmask;
    logic [31:0] bmask;

    assign frozen = (g == 1) && pair;

    // The upper setup register is frozen while it serves as the top half of the pair.
    assign setup_wr = reg_wr && reg_addr == SETUP_OFS && !frozen; // RL13
    assign wmask = (g == 0) ? mask_lo : mask_up;
    assign bmask = frozen ? mask_lo[63:32] : wmask[31:0];

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        space_r[g] <= ntbw_pkg::SPACE_RST;
        pref_r[g] <= ntbw_pkg::PREF_RST;
        size_r[g] <= ntbw_pkg::SIZE_RST;
      end else if (setup_wr) begin
        space_r[g] <= reg_wdata[ntbw_pkg::SPACE_BIT];
        pref_r[g] <= reg_wdata[ntbw_pkg::PREF_BIT];
        size_r[g] <= reg_wdata[ntbw_pkg::SIZE_MSB:ntbw_pkg::SIZE_LSB]; // RL6 RL7
      end
    end

    // I/O space always decodes 32-bit; only the lower window may select 64-bit.
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        type_r[g] <= ntbw_pkg::TYPE_RST;
      end else if (setup_wr) begin
        if (reg_wdata[ntbw_pkg::SPACE_BIT] != ntbw_pkg::SPACE_MEM || g == 1) begin
          type_r[g] <= ntbw_pkg::TYPE_ADDR32;
        end else begin
          type_r[g] <= reg_wdata[ntbw_pkg::TYPE_MSB:ntbw_pkg::TYPE_LSB];
        end
      end
    end

    // Only por clears these; rst still resets size to one and base, so the window stops decoding.
    always_ff @(posedge clk or posedge por) begin
      if (por) begin
        en_r[g] <= ntbw_pkg::EN_RST; // RL9
      end else if (setup_wr) begin
        en_r[g] <= reg_wdata[ntbw_pkg::EN_BIT];
      end
    end

    always_ff @(posedge clk or posedge por) begin
      if (por) begin
        tbase_r[g] <= ntbw_pkg::TBASE_RST; // RL9
      end else if (reg_wr && reg_addr == TBASE_OFS) begin
        tbase_r[g][31:ntbw_pkg::BASE_LSB] <= reg_wdata[31:ntbw_pkg::BASE_LSB];
        // The low nibble is taken only while the pair is formed.
        if (frozen) begin
          tbase_r[g][ntbw_pkg::BASE_LSB-1:0] <= reg_wdata[ntbw_pkg::BASE_LSB-1:0]; // RL11
        end
      end
    end

    // Masking at write and again at read keeps bits hidden after a later size change.
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        base_r[g] <= ntbw_pkg::BASE_RST;
      end else if (reg_wr && reg_addr == BASE_OFS) begin
        base_r[g] <= reg_wdata & bmask; // RL2 RL4
      end
    end

    assign setup_rd[g] = frozen ? 32'h0000_0000 : // RL13
      setup_word(en_r[g], size_r[g], pref_r[g], type_r[g], space_r[g]);
    assign tbase_rd[g] = tbase_word(tbase_r[g], frozen); // RL11
  end

  // An enable that is clear makes the window's base register read zero.
  always_comb begin
    base_rd[0] = 32'h0000_0000;
    base_rd[1] = 32'h0000_0000;
    if (en_r[0]) begin // RL8
      base_rd[0] = (base_r[0] & mask_lo[31:0]) | attr_bits(pref_r[0], type_r[0], space_r[0]);
    end
    if (pair) begin
      if (en_r[0]) begin // RL8
        base_rd[1] = base_r[1] & mask_lo[63:32]; // RL3
      end
    end else if (en_r[1]) begin // RL8
      base_rd[1] = (base_r[1] & mask_up[31:0]) | attr_bits(pref_r[1], type_r[1], space_r[1]);
    end
  end

  // Unmapped offsets read zero.
  always_comb begin
    case (reg_addr)
      ntbw_pkg::OFS_LO_SETUP: rdata_nxt = setup_rd[0];
      ntbw_pkg::OFS_UP_SETUP: rdata_nxt = setup_rd[1];
      ntbw_pkg::OFS_LO_TBASE: rdata_nxt = tbase_rd[0];
      ntbw_pkg::OFS_UP_TBASE: rdata_nxt = tbase_rd[1];
      ntbw_pkg::OFS_LO_BASE: rdata_nxt = base_rd[0];
      ntbw_pkg::OFS_UP_BASE: rdata_nxt = base_rd[1];
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe; idle cycles show zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Lower window candidate; in pair mode it spans all 64 address bits.
  always_comb begin
    lo_mask = pair ? mask_lo : {32'h0, mask_lo[31:0]};
    lo_base = {pair ? base_r[1] : 32'h0, base_r[0][31:ntbw_pkg::BASE_LSB], 4'h0};
    lo_tbase = {pair ? tbase_r[1] : 32'h0, tbase_r[0][31:ntbw_pkg::BASE_LSB], 4'h0}; // RL10
    lo_valid = en_r[0];
  end

  // Upper window candidate, used only while the pair is split.
  always_comb begin
    up_mask = {32'h0, mask_up[31:0]};
    up_base = {32'h0, base_r[1][31:ntbw_pkg::BASE_LSB], 4'h0};
    up_tbase = {32'h0, tbase_r[1][31:ntbw_pkg::BASE_LSB], 4'h0};
    up_valid = en_r[1];
  end

  // The upper window never decodes on its own while it is the top half of the pair.
  always_comb begin
    case ({xl_win, pair})
      2'h0, 2'h1: begin
        xl_mask = lo_mask;
        xl_base = lo_base;
        xl_tbase = lo_tbase;
        xl_valid = lo_valid;
      end
      2'h2: begin
        xl_mask = up_mask;
        xl_base = up_base;
        xl_tbase = up_tbase;
        xl_valid = up_valid;
      end
      default: begin
        xl_mask = 64'h0;
        xl_base = 64'h0;
        xl_tbase = 64'h0;
        xl_valid = 1'b0;
      end
    endcase
  end

  // A 32-bit window ignores any request whose upper address half is nonzero.
  always_comb begin
    out_nxt = (xl_addr & ~xl_mask) | (xl_tbase & xl_mask); // RL12 RL14
    addr_match = ((xl_addr ^ xl_base) & xl_mask) == 64'h0;
    span_ok = (pair && !xl_win) || (xl_addr[63:32] == 32'h0);
    hit_nxt = xl_valid && (xl_mask != 64'h0) && addr_match && span_ok; // RL5 RL8
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xl_ack <= 1'b0;
    end else begin
      xl_ack <= xl_req;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xl_hit <= 1'b0;
    end else begin
      xl_hit <= xl_req && hit_nxt;
    end
  end

  // Without a request the output echoes the address, so idle cycles carry no stale translation.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xl_out <= 64'h0;
    end else begin
      xl_out <= xl_req ? out_nxt : xl_addr;
    end
  end

endmodule

// *** tb/ntbw_window_props.sv ***
// Purpose: Port checks for the window pair.
// Assumes: Lower setup is written only at its own offset.
// Notes: A shadow of lower setup judges reads.
`timescale 1ns/1ps
module ntbw_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [ntbw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic xl_req,
  input wire logic xl_win,
  input wire logic [63:0] xl_addr,
  input wire logic xl_ack,
  input wire logic xl_hit,
  input wire logic [63:0] xl_out
);
  logic [9:0] set_r;
  logic en_r, sw, sm, pair;
  assign sw = reg_wr && reg_addr == ntbw_pkg::OFS_LO_SETUP;
  assign sm = set_r[9:4] != 6'h00 && set_r[9:4] < 6'h04;
  assign pair = set_r[2:0] == 3'h4;
  // Enable outlives hot reset, so only por clears its shadow.
  always_ff @(posedge clk or posedge por) if (por) en_r <= 1'b0; else if (sw) en_r <= reg_wdata[31];
  always_ff @(posedge clk or posedge rst) if (rst) set_r <= 10'h010; else if (sw) set_r <= reg_wdata[9:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_brd; reg_rd && reg_addr == ntbw_pkg::OFS_LO_BASE; endsequence
  sequence s_lxl; xl_req && !xl_win; endsequence
  property p_ack; xl_req |=> xl_ack; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_idle; !xl_req |=> !xl_ack && !xl_hit; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_low; xl_req |=> xl_out[3:0] == $past(xl_addr[3:0]); endproperty
  a_low: assert property (p_low) else $error("low bits changed");
  property p_smx; s_lxl ##0 sm |=> !xl_hit; endproperty
  a_smx: assert property (p_smx) else $error("small window hit");
  property p_smr; s_brd ##0 sm |=> reg_rdata[31:4] == 28'h0; endproperty
  a_smr: assert property (p_smr) else $error("small window base");
  property p_off; s_brd ##0 !en_r |=> reg_rdata == 32'h0; endproperty
  a_off: assert property (p_off) else $error("disabled base");
  property p_offx; s_lxl ##0 !en_r |=> !xl_hit; endproperty
  a_offx: assert property (p_offx) else $error("disabled hit");
  property p_up0; reg_rd && reg_addr == ntbw_pkg::OFS_UP_SETUP && pair |=> reg_rdata == 32'h0; endproperty
  a_up0: assert property (p_up0) else $error("upper setup");
endmodule
bind ntbw_window ntbw_props u_props (.clk(clk), .rst(rst), .por(por), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xl_req(xl_req), .xl_win(xl_win), .xl_addr(xl_addr),
  .xl_ack(xl_ack), .xl_hit(xl_hit), .xl_out(xl_out));

// *** tb/ntbw_host.sv ***
// Purpose: Far-side host that issues translations.
// Assumes: Called just after a rising edge.
// Notes: A released address shows its inverse.
`timescale 1ns/1ps
module ntbw_host (
  input wire logic clk,
  output logic xl_req,
  output logic xl_win,
  output logic [63:0] xl_addr
);
  initial begin
    xl_req = 1'b0;
    xl_win = 1'b0;
    xl_addr = 64'h0;
  end
  task automatic send(input logic w, input logic [63:0] a);
    xl_req <= 1'b1;
    xl_win <= w;
    xl_addr <= a;
    @(posedge clk);
    xl_req <= 1'b0;
    xl_addr <= ~a;
  endtask
endmodule

// *** tb/tb_ntb_bar_window_size_translate.sv ***
// Purpose: Self-checking bench for the window pair.
// Assumes: Lower window is also set to a 16-byte I/O size and to size three.
// Notes: Each task ends one edge after its strobe drops.
`timescale 1ns/1ps
module tb_ntb_bar_window_size_translate;
  logic clk = 0, rst = 1, por = 1, reg_wr = 0, reg_rd = 0, xl_req, xl_win, xl_ack, xl_hit;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [63:0] xl_addr, xl_out;
  logic [31:0] su[4] = '{32'h8000_0080, 32'h8000_0000, 32'h8000_0041, 32'h8000_0030};
  logic [31:0] bx[4] = '{32'hffff_ff00, 32'hffff_fff0, 32'hffff_fff1, 32'h0};
  int err_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  ntbw_window dut (.clk(clk), .rst(rst), .por(por), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xl_req(xl_req), .xl_win(xl_win), .xl_addr(xl_addr), .xl_ack(xl_ack),
    .xl_hit(xl_hit), .xl_out(xl_out));
  ntbw_host host (.clk(clk), .xl_req(xl_req), .xl_win(xl_win), .xl_addr(xl_addr));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1 chk("rdata_idle", 64'h0, {32'h0, reg_rdata});
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", {32'h0, e}, {32'h0, reg_rdata});
    @(posedge clk);
  endtask
  task automatic xl(input logic w, input logic [63:0] a, input logic h, input logic [63:0] e);
    host.send(w, a);
    #1 chk("ack_hit", {62'h0, 1'b1, h}, {62'h0, xl_ack, xl_hit});
    if (h) chk("xl_out", e, xl_out);
    @(posedge clk);
  endtask
  task automatic t_size();
    rd(ntbw_pkg::OFS_LO_SETUP, 32'h10);
    rd(8'h00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ntbw_pkg::OFS_LO_SETUP, su[i]);
      wr(ntbw_pkg::OFS_LO_BASE, 32'hffff_ffff);
      rd(ntbw_pkg::OFS_LO_BASE, bx[i]);
    end
    xl(1'b0, 64'h10, 1'b0, 64'h0);
  endtask
  task automatic t_xl32();
    wr(ntbw_pkg::OFS_LO_SETUP, 32'h8000_0080);
    wr(ntbw_pkg::OFS_LO_BASE, 32'h1234_5600);
    wr(ntbw_pkg::OFS_LO_SETUP, 32'h0000_0080);
    rd(ntbw_pkg::OFS_LO_BASE, 32'h0);
    xl(1'b0, 64'h1234_5678, 1'b0, 64'h0);
    wr(ntbw_pkg::OFS_LO_SETUP, 32'h8000_0080);
    wr(ntbw_pkg::OFS_LO_TBASE, 32'habcd_ef00);
    xl(1'b0, 64'h1234_5678, 1'b1, 64'habcd_ef78);
    xl(1'b0, 64'h1234_5778, 1'b0, 64'h0);
  endtask
  task automatic t_pair();
    wr(ntbw_pkg::OFS_LO_SETUP, 32'h8000_0084);
    wr(ntbw_pkg::OFS_UP_SETUP, 32'h8000_00c0);
    rd(ntbw_pkg::OFS_UP_SETUP, 32'h0);
    wr(ntbw_pkg::OFS_UP_TBASE, 32'hffff_ffff);
    rd(ntbw_pkg::OFS_UP_TBASE, 32'hffff_ffff);
    wr(ntbw_pkg::OFS_UP_BASE, 32'h1);
    rd(ntbw_pkg::OFS_LO_BASE, 32'h1234_5604);
    xl(1'b0, 64'h1_1234_5678, 1'b1, 64'hffff_ffff_abcd_ef78);
    xl(1'b1, 64'h1_1234_5678, 1'b0, 64'h0);
  endtask
  task automatic t_hot();
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ntbw_pkg::OFS_LO_SETUP, 32'h8000_0010);
    rd(ntbw_pkg::OFS_LO_TBASE, 32'habcd_ef00);
    rd(ntbw_pkg::OFS_UP_TBASE, 32'hffff_fff0);
    wr(ntbw_pkg::OFS_UP_SETUP, 32'h8000_0090);
    wr(ntbw_pkg::OFS_UP_BASE, 32'h2000_0000);
    wr(ntbw_pkg::OFS_UP_TBASE, 32'h4000_0000);
    rd(ntbw_pkg::OFS_UP_SETUP, 32'h8000_0090);
    rd(ntbw_pkg::OFS_UP_BASE, 32'h2000_0000);
    xl(1'b1, 64'h2000_0123, 1'b1, 64'h4000_0123);
    xl(1'b1, 64'h1_2000_0123, 1'b0, 64'h0);
  endtask
  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    t_size();
    t_xl32();
    t_pair();
    t_hot();
    end_sim();
  end
  // Whole run needs about 90 cycles; the limit leaves ample slack.
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule
